//--- logic/liu_cfg_pkg.sv
// constants of the global configuration register bank of a quad line interface
// assumes one 100 MHz core clock and a parallel host port with 7-bit addresses
// Notes on behaviour
// - segment-eight amplitude is 7-bit signed magnitude, bit 6 sign, bit 0 lsb
// - rail bit 1 gives single-rail data on all channels, 0 dual-rail
// - auto-ones bit 1 sends all ones on channels with receive signal loss
// - receive-edge bit 1 updates receive data on falling edge, 0 rising
// - transmit-edge bit 0 samples transmit data on falling edge, 1 rising
// - polarity bit 1 makes transmit inputs and receive outputs active low
// - channel interrupts reach the output only while global enable is 1
// - soft reset starts only after the bit stays 1 longer than 10 us
// - during soft reset internal logic is held, host registers keep values
// - changing the clock select or master rate bits (6:3) retunes the clock synthesizer
package liu_cfg_pkg;
    localparam logic [6:0] ADDR_SEG8_CH0 = 7'h0f;
    localparam logic [6:0] ADDR_SEG8_CH1 = 7'h1f;
    localparam logic [6:0] ADDR_SEG8_CH2 = 7'h2f;
    localparam logic [6:0] ADDR_SEG8_CH3 = 7'h3f;
    localparam logic [6:0] ADDR_GLOBAL_CFG = 7'h40;
    localparam logic [6:0] ADDR_CLK_SELECT = 7'h41;
    localparam int CH_FIELD_LSB = 4;
    localparam logic [2:0] SEG8_LOW_NIBBLE = 3'h7;
    localparam int BIT_RAIL = 7;
    localparam int BIT_AUTO_ONES = 6;
    localparam int BIT_RX_EDGE = 5;
    localparam int BIT_TX_EDGE = 4;
    localparam int BIT_POLARITY = 3;
    localparam int BIT_IRQ_EN = 1;
    localparam int BIT_SOFT_RST = 0;
    localparam logic [7:0] GLOBAL_CFG_WMASK = 8'hfb;
    localparam logic [7:0] SEG8_WMASK = 8'h7f;
    localparam logic [7:0] CLK_GROUP_MASK = 8'h78;
    localparam logic [7:0] GLOBAL_CFG_RESET = 8'h00;
    localparam logic [7:0] SEG8_RESET = 8'h00;
    localparam logic [7:0] CLK_SELECT_RESET = 8'h00;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SOFT_RST_TIME_NS = 10000;
    localparam int SOFT_RST_CYCLES = (SOFT_RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SEGMENTS = 8;
    localparam logic [2:0] LAST_SEGMENT = 3'h7;
endpackage

//--- logic/liu_global_config_regs.sv
// global configuration registers, segment-eight amplitude registers and data path
// assumes host pins are asynchronous to clk; transmit data is synchronous to the link clock
module line_word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clear,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] rd;
        logic [PW-1:0] wr;
        logic [PW:0] cnt;
    } fifo_t;
    fifo_t st_ff;
    fifo_t nxt_st;
    logic push;
    logic pop;

    assign in_ready = (st_ff.cnt != (PW+1)'(DEPTH));
    assign out_valid = (st_ff.cnt != '0);
    assign out_data = st_ff.mem[st_ff.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb
    begin
        nxt_st = st_ff;
        if (push)
        begin
            nxt_st.mem[st_ff.wr] = in_data;
            nxt_st.wr = (st_ff.wr == PW'(DEPTH - 1)) ? '0 : st_ff.wr + 1'b1;
        end
        if (pop)
            nxt_st.rd = (st_ff.rd == PW'(DEPTH - 1)) ? '0 : st_ff.rd + 1'b1;
        nxt_st.cnt = st_ff.cnt + (PW+1)'(push) - (PW+1)'(pop);
        if (clear)
            nxt_st = '0;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    a_fifo_no_overrun: assert property (@(posedge clk) disable iff (!reset_n)
        st_ff.cnt <= (PW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule // line_word_fifo

module liu_global_config_regs #(
    parameter int NCH = 4,
    parameter int SEG_CYCLES = 1,
    parameter int RST_CYCLES = liu_cfg_pkg::SOFT_RST_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic host_cs_n,
    input wire logic host_wr_n,
    input wire logic host_rd_n,
    input wire logic [6:0] host_addr,
    input wire logic [7:0] host_data_in,
    output logic [7:0] host_data_out,
    output logic host_data_oe,
    input wire logic tx_line_clock,
    input wire logic [NCH-1:0] tx_positive_data,
    input wire logic [NCH-1:0] tx_negative_data,
    input wire logic [NCH-1:0] rx_recovered_data,
    output logic [NCH-1:0] rx_data_out,
    input wire logic [NCH-1:0] receive_signal_loss,
    input wire logic [NCH-1:0] channel_irq,
    output logic irq_n,
    output logic [NCH-1:0][6:0] pulse_amplitude,
    output logic [2:0] pulse_segment,
    output logic [7:0] clock_select,
    output logic pll_retune,
    output logic internal_reset,
    output logic single_rail
);
    localparam int W = 2 * NCH;
    localparam int RW = $clog2(RST_CYCLES + 2);

    typedef struct packed {
        logic cs_s1, cs_s2, wr_s1, wr_s2, wr_d, rd_s1, rd_s2;
        logic [6:0] addr_s1, addr_s2;
        logic [7:0] wd_s1, wd_s2;
        logic [NCH-1:0][7:0] seg8;
        logic [7:0] gcfg;
        logic [7:0] csel;
        logic retune;
        logic [7:0] rdata;
        logic oe;
        logic [RW-1:0] rst_cnt;
        logic int_rst;
        logic [NCH-1:0] loss_s1, loss_s2, irq_s1, irq_s2;
        logic irq_out;
        logic tog_s1, tog_s2, tog_d;
        logic pend;
        logic [W-1:0] pend_word;
        logic busy;
        logic [2:0] seg;
        logic [7:0] seg_cyc;
        logic [W-1:0] cur;
        logic ones_phase;
        logic [NCH-1:0][6:0] amp;
    } core_t;

    typedef struct packed {
        logic [3:0] cfg_s1, cfg_s2;
        logic [W-1:0] word;
        logic tog;
        logic [NCH-1:0] rx_p;
    } lpos_t;

    typedef struct packed {
        logic [W-1:0] cap;
        logic [NCH-1:0] rx_n;
    } lneg_t;

    core_t st_ff;
    core_t nxt_st;
    lpos_t lp_ff;
    lpos_t nxt_lp;
    lneg_t ln_ff;
    lneg_t nxt_ln;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_take;
    logic [W-1:0] fifo_out_data;

    function automatic logic [7:0] read_reg(input core_t s, input logic [6:0] a);
        logic [7:0] r;
        r = 8'h00;
        if (a == liu_cfg_pkg::ADDR_GLOBAL_CFG)
            r = s.gcfg & liu_cfg_pkg::GLOBAL_CFG_WMASK;
        else if (a == liu_cfg_pkg::ADDR_CLK_SELECT)
            r = s.csel;
        else if (a[3:0] == 4'hf && a[6:4] < 3'(NCH))
            r = s.seg8[a[5:4]] & liu_cfg_pkg::SEG8_WMASK;
        return r;
    endfunction

    assign fifo_take = !st_ff.busy && !st_ff.int_rst;

    line_word_fifo #(.WIDTH(W), .DEPTH(4)) u_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .clear(st_ff.int_rst),
        .in_valid(st_ff.pend),
        .in_ready(fifo_in_ready),
        .in_data(st_ff.pend_word),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_take),
        .out_data(fifo_out_data)
    );

    always_comb
    begin
        logic wr_evt;
        logic [6:0] a;
        logic [NCH-1:0] p;
        logic [NCH-1:0] n;
        nxt_st = st_ff;
        wr_evt = st_ff.wr_s2 && !st_ff.wr_d && st_ff.cs_s2;
        a = st_ff.addr_s2;
        p = '0;
        n = '0;
        nxt_st.cs_s1 = !host_cs_n;
        nxt_st.cs_s2 = st_ff.cs_s1;
        nxt_st.wr_s1 = !host_wr_n;
        nxt_st.wr_s2 = st_ff.wr_s1;
        nxt_st.wr_d = st_ff.wr_s2;
        nxt_st.rd_s1 = !host_rd_n;
        nxt_st.rd_s2 = st_ff.rd_s1;
        nxt_st.addr_s1 = host_addr;
        nxt_st.addr_s2 = st_ff.addr_s1;
        nxt_st.wd_s1 = host_data_in;
        nxt_st.wd_s2 = st_ff.wd_s1;
        nxt_st.loss_s1 = receive_signal_loss;
        nxt_st.loss_s2 = st_ff.loss_s1;
        nxt_st.irq_s1 = channel_irq;
        nxt_st.irq_s2 = st_ff.irq_s1;
        nxt_st.tog_s1 = lp_ff.tog;
        nxt_st.tog_s2 = st_ff.tog_s1;
        nxt_st.tog_d = st_ff.tog_s2;
        nxt_st.retune = 1'b0;
        // host registers are never touched by the soft reset
        if (wr_evt)
        begin
            if (a == liu_cfg_pkg::ADDR_GLOBAL_CFG)
                nxt_st.gcfg = st_ff.wd_s2 & liu_cfg_pkg::GLOBAL_CFG_WMASK;
            else if (a == liu_cfg_pkg::ADDR_CLK_SELECT)
            begin
                nxt_st.csel = st_ff.wd_s2;
                nxt_st.retune = |((st_ff.wd_s2 ^ st_ff.csel) & liu_cfg_pkg::CLK_GROUP_MASK);
            end
            else if (a[3:0] == 4'hf && a[6:4] < 3'(NCH))
                nxt_st.seg8[a[5:4]] = st_ff.wd_s2 & liu_cfg_pkg::SEG8_WMASK;
        end
        nxt_st.oe = st_ff.cs_s2 && st_ff.rd_s2;
        nxt_st.rdata = read_reg(st_ff, a);
        // soft reset qualifies only after the bit has stayed set past the limit
        if (!st_ff.gcfg[liu_cfg_pkg::BIT_SOFT_RST])
        begin
            nxt_st.rst_cnt = '0;
            nxt_st.int_rst = 1'b0;
        end
        else if (st_ff.rst_cnt > RW'(RST_CYCLES))
            nxt_st.int_rst = 1'b1;
        else
            nxt_st.rst_cnt = st_ff.rst_cnt + 1'b1;
        nxt_st.irq_out = st_ff.gcfg[liu_cfg_pkg::BIT_IRQ_EN] && |st_ff.irq_s2
            && !st_ff.int_rst;
        if (st_ff.tog_s2 != st_ff.tog_d)
        begin
            nxt_st.pend = 1'b1;
            nxt_st.pend_word = lp_ff.word;
        end
        else if (st_ff.pend && fifo_in_ready)
            nxt_st.pend = 1'b0;
        // eight segments per word, the eighth carries the programmed amplitude
        if (st_ff.busy)
        begin
            if (st_ff.seg_cyc == 8'(SEG_CYCLES - 1))
            begin
                nxt_st.seg_cyc = '0;
                nxt_st.seg = st_ff.seg + 1'b1;
                if (st_ff.seg == liu_cfg_pkg::LAST_SEGMENT)
                    nxt_st.busy = 1'b0;
            end
            else
                nxt_st.seg_cyc = st_ff.seg_cyc + 1'b1;
        end
        else if (fifo_out_valid)
        begin
            p = fifo_out_data[NCH-1:0];
            n = st_ff.gcfg[liu_cfg_pkg::BIT_RAIL] ? '0 : fifo_out_data[W-1:NCH];
            for (int c = 0; c < NCH; c++)
            begin
                if (st_ff.gcfg[liu_cfg_pkg::BIT_AUTO_ONES] && st_ff.loss_s2[c])
                begin
                    p[c] = st_ff.gcfg[liu_cfg_pkg::BIT_RAIL] || !st_ff.ones_phase;
                    n[c] = !st_ff.gcfg[liu_cfg_pkg::BIT_RAIL] && st_ff.ones_phase;
                end
            end
            nxt_st.cur = {n, p};
            nxt_st.ones_phase = !st_ff.ones_phase;
            nxt_st.busy = 1'b1;
            nxt_st.seg = '0;
            nxt_st.seg_cyc = '0;
        end
        for (int c = 0; c < NCH; c++)
        begin
            nxt_st.amp[c] = '0;
            if (st_ff.busy && st_ff.seg == liu_cfg_pkg::LAST_SEGMENT
                && (st_ff.cur[c] || st_ff.cur[NCH+c]))
                nxt_st.amp[c] = {st_ff.seg8[c][6] ^ st_ff.cur[NCH+c],
                    st_ff.seg8[c][5:0]};
        end
        if (st_ff.int_rst)
        begin
            nxt_st.pend = 1'b0;
            nxt_st.busy = 1'b0;
            nxt_st.seg = '0;
            nxt_st.amp = '0;
            nxt_st.ones_phase = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_ff <= '0;
            st_ff.gcfg <= liu_cfg_pkg::GLOBAL_CFG_RESET;
            st_ff.csel <= liu_cfg_pkg::CLK_SELECT_RESET;
            st_ff.seg8 <= {NCH{liu_cfg_pkg::SEG8_RESET}};
        end
        else
            st_ff <= nxt_st;
    end

    // link side: configuration levels cross by two flip-flops
    always_comb
    begin
        logic [W-1:0] smp;
        logic inv;
        nxt_lp = lp_ff;
        nxt_lp.cfg_s1 = {st_ff.int_rst, st_ff.gcfg[liu_cfg_pkg::BIT_POLARITY],
            st_ff.gcfg[liu_cfg_pkg::BIT_RX_EDGE], st_ff.gcfg[liu_cfg_pkg::BIT_TX_EDGE]};
        nxt_lp.cfg_s2 = lp_ff.cfg_s1;
        inv = lp_ff.cfg_s2[2];
        smp = lp_ff.cfg_s2[0] ? {tx_negative_data, tx_positive_data} : ln_ff.cap;
        nxt_lp.word = inv ? ~smp : smp;
        nxt_lp.tog = !lp_ff.tog;
        nxt_lp.rx_p = inv ? ~rx_recovered_data : rx_recovered_data;
        if (lp_ff.cfg_s2[3])
        begin
            nxt_lp.tog = lp_ff.tog;
            nxt_lp.rx_p = '0;
        end
    end

    always_comb
    begin
        nxt_ln = ln_ff;
        nxt_ln.cap = {tx_negative_data, tx_positive_data};
        nxt_ln.rx_n = lp_ff.cfg_s2[2] ? ~rx_recovered_data : rx_recovered_data;
        if (lp_ff.cfg_s2[3])
            nxt_ln.rx_n = '0;
    end

    always_ff @(posedge tx_line_clock or negedge reset_n)
    begin
        if (!reset_n)
            lp_ff <= '0;
        else
            lp_ff <= nxt_lp;
    end

    always_ff @(negedge tx_line_clock or negedge reset_n)
    begin
        if (!reset_n)
            ln_ff <= '0;
        else
            ln_ff <= nxt_ln;
    end

    assign rx_data_out = lp_ff.cfg_s2[1] ? ln_ff.rx_n : lp_ff.rx_p;
    assign host_data_out = st_ff.rdata;
    assign host_data_oe = st_ff.oe;
    assign irq_n = !st_ff.irq_out;
    assign pulse_amplitude = st_ff.amp;
    assign pulse_segment = st_ff.seg;
    assign clock_select = st_ff.csel;
    assign pll_retune = st_ff.retune;
    assign internal_reset = st_ff.int_rst;
    assign single_rail = st_ff.gcfg[liu_cfg_pkg::BIT_RAIL];

    a_irq_gated: assert property (@(posedge clk) disable iff (!reset_n)
        !st_ff.gcfg[liu_cfg_pkg::BIT_IRQ_EN] |=> irq_n) else $error("irq while disabled");
    a_rst_not_early: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(st_ff.int_rst) |-> st_ff.rst_cnt > RW'(RST_CYCLES)) else $error("early reset");
    a_rst_holds: assert property (@(posedge clk) disable iff (!reset_n)
        st_ff.int_rst && st_ff.gcfg[0] |=> st_ff.int_rst && pulse_amplitude == '0)
        else $error("soft reset dropped");
    a_reg_kept: assert property (@(posedge clk) disable iff (!reset_n)
        st_ff.int_rst && !(st_ff.wr_s2 && !st_ff.wr_d) |=> $stable(st_ff.seg8))
        else $error("register lost in reset");
    a_retune_pulse: assert property (@(posedge clk) disable iff (!reset_n)
        pll_retune |-> (($past(st_ff.csel) ^ clock_select) & 8'h78) != 8'h00
        ##1 !pll_retune) else $error("bad retune");
    a_reserved_zero: assert property (@(posedge clk) disable iff (!reset_n)
        !st_ff.gcfg[2] && st_ff.seg8[0][7] == 1'b0) else $error("reserved bit set");
    a_amp_last_only: assert property (@(posedge clk) disable iff (!reset_n)
        pulse_amplitude != '0 |-> $past(st_ff.seg) == 3'h7) else $error("amp outside seg8");
    a_single_rail: assert property (@(posedge clk) disable iff (!reset_n)
        st_ff.busy && single_rail && $rose(st_ff.busy) |-> st_ff.cur[W-1:NCH] == '0)
        else $error("negative rail in single-rail");
    a_tx_edge: assert property (@(posedge tx_line_clock) disable iff (!reset_n)
        !lp_ff.cfg_s2[0] && !lp_ff.cfg_s2[2] && !lp_ff.cfg_s2[3] |=>
        lp_ff.word == $past(ln_ff.cap)) else $error("wrong sampling edge");
    a_rx_pol: assert property (@(posedge tx_line_clock) disable iff (!reset_n)
        lp_ff.cfg_s2[2] && !lp_ff.cfg_s2[3] && $stable(lp_ff.cfg_s2) |=>
        lp_ff.rx_p == ~$past(rx_recovered_data)) else $error("polarity not applied");

    c_soft_reset: cover property (@(posedge clk) disable iff (!reset_n) $rose(st_ff.int_rst));
    c_pulse_out: cover property (@(posedge clk) disable iff (!reset_n) pulse_amplitude != '0);
    c_fifo_full: cover property (@(posedge clk) disable iff (!reset_n) !fifo_in_ready);
    c_retune: cover property (@(posedge clk) disable iff (!reset_n) pll_retune);
endmodule // liu_global_config_regs

//--- dv/line_partner.sv
// far-side line model: framer that makes the link clock and the line data
// assumes the bench steers it through run, send and the data inputs
module line_partner #(
    parameter int NCH = 4
) (
    input wire logic run,
    input wire logic send,
    input wire logic at_fall,
    input wire logic [NCH-1:0] pos,
    input wire logic [NCH-1:0] neg,
    input wire logic [NCH-1:0] rx_bits,
    output logic tx_line_clock,
    output logic [NCH-1:0] tx_positive_data,
    output logic [NCH-1:0] tx_negative_data,
    output logic [NCH-1:0] rx_recovered_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // link clock stands low between frames
    initial
    begin
        tx_line_clock = 1'h0;
        forever
        begin
            #40;
            if (run || tx_line_clock)
                tx_line_clock = ~tx_line_clock;
        end
    end
    // one word held for half a period, centred on one edge only
    initial
    begin
        tx_positive_data = '0;
        tx_negative_data = '0;
        forever
        begin
            @(posedge send);
            if (at_fall)
                @(posedge tx_line_clock);
            else
                @(negedge tx_line_clock);
            #20;
            tx_positive_data = pos;
            tx_negative_data = neg;
            #40;
            tx_positive_data = '0;
            tx_negative_data = '0;
        end
    end
    // receive data moves a quarter period after the rising edge
    initial
    begin
        rx_recovered_data = '0;
        forever
        begin
            @(posedge tx_line_clock);
            #20;
            rx_recovered_data = rx_bits;
        end
    end
endmodule // line_partner

//--- dv/testbench.sv
// self-checking bench of the global configuration register bank
// assumes the line partner model and a shortened soft reset count of 8
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NCH = 4;
    logic clk, reset_n, host_cs_n, host_wr_n, host_rd_n, host_data_oe, tx_line_clock;
    logic irq_n, pll_retune, internal_reset, single_rail, run, send, at_fall, seg_last;
    logic [6:0] host_addr;
    logic [6:0] amp;
    logic [7:0] host_data_in, host_data_out, clock_select, rd;
    logic [NCH-1:0] tx_positive_data, tx_negative_data, rx_recovered_data, rx_data_out;
    logic [NCH-1:0] receive_signal_loss, channel_irq, pos, neg, rx_bits;
    logic [NCH-1:0][6:0] pulse_amplitude;
    logic [2:0] pulse_segment;
    int n_mismatch = 0;
    int compares = 0;
    int n_retune = 0;

    liu_global_config_regs #(.RST_CYCLES(8)) dut_u (.clk(clk), .reset_n(reset_n),
        .host_cs_n(host_cs_n), .host_wr_n(host_wr_n), .host_rd_n(host_rd_n),
        .host_addr(host_addr), .host_data_in(host_data_in), .host_data_out(host_data_out),
        .host_data_oe(host_data_oe), .tx_line_clock(tx_line_clock),
        .tx_positive_data(tx_positive_data), .tx_negative_data(tx_negative_data),
        .rx_recovered_data(rx_recovered_data), .rx_data_out(rx_data_out),
        .receive_signal_loss(receive_signal_loss), .channel_irq(channel_irq), .irq_n(irq_n),
        .pulse_amplitude(pulse_amplitude), .pulse_segment(pulse_segment),
        .clock_select(clock_select), .pll_retune(pll_retune),
        .internal_reset(internal_reset), .single_rail(single_rail));
    line_partner #(.NCH(NCH)) partner_u (.run(run), .send(send), .at_fall(at_fall),
        .pos(pos), .neg(neg), .rx_bits(rx_bits), .tx_line_clock(tx_line_clock),
        .tx_positive_data(tx_positive_data), .tx_negative_data(tx_negative_data),
        .rx_recovered_data(rx_recovered_data));

    initial
    begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    always @(negedge clk)
        if (pll_retune === 1'h1)
            n_retune++;

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic host_write(input logic [6:0] a, input logic [7:0] d);
        @(negedge clk);
        host_addr = a;
        host_data_in = d;
        host_cs_n = 1'h0;
        host_wr_n = 1'h0;
        repeat (5) @(negedge clk);
        host_wr_n = 1'h1;
        host_cs_n = 1'h1;
        repeat (5) @(negedge clk);
    endtask
    task automatic host_read(input logic [6:0] a, output logic [7:0] d);
        @(negedge clk);
        host_addr = a;
        host_cs_n = 1'h0;
        host_rd_n = 1'h0;
        repeat (6) @(negedge clk);
        d = host_data_out;
        check("read_oe", {7'h00, host_data_oe}, 8'h01);
        host_rd_n = 1'h1;
        host_cs_n = 1'h1;
        repeat (5) @(negedge clk);
    endtask
    // runs the link for one word and keeps the last nonzero amplitude of channel ch
    task automatic send_word(input logic [3:0] p, input logic [3:0] n, input logic f,
        input int ch, output logic [6:0] s);
        s = 7'h00;
        seg_last = 1'h0;
        pos = p;
        neg = n;
        at_fall = f;
        run = 1'h1;
        // let the edge and polarity settings cross into the link domain first
        repeat (3) @(posedge tx_line_clock);
        @(negedge clk);
        send = 1'h1;
        @(negedge clk);
        send = 1'h0;
        repeat (80) @(negedge clk)
        begin
            if (pulse_amplitude[ch] !== 7'h00)
                s = pulse_amplitude[ch];
            if (pulse_segment === liu_cfg_pkg::LAST_SEGMENT)
                seg_last = 1'h1;
        end
        run = 1'h0;
        repeat (30) @(negedge clk);
    endtask

    task automatic t_reset();
        logic [6:0] addrs[7] = '{liu_cfg_pkg::ADDR_SEG8_CH0, liu_cfg_pkg::ADDR_SEG8_CH1,
            liu_cfg_pkg::ADDR_SEG8_CH2, liu_cfg_pkg::ADDR_SEG8_CH3,
            liu_cfg_pkg::ADDR_GLOBAL_CFG, liu_cfg_pkg::ADDR_CLK_SELECT, 7'h50};
        foreach (addrs[i])
        begin
            host_read(addrs[i], rd);
            check("reset_value", rd, 8'h00);
        end
        check("irq_n_idle", {7'h00, irq_n}, 8'h01);
        $display("test reset done");
    endtask
    task automatic t_regs();
        host_write(liu_cfg_pkg::ADDR_SEG8_CH2, 8'hff);
        host_read(liu_cfg_pkg::ADDR_SEG8_CH2, rd);
        check("seg8_rw", rd, 8'h7f);
        host_write(liu_cfg_pkg::ADDR_GLOBAL_CFG, 8'hfe);
        host_read(liu_cfg_pkg::ADDR_GLOBAL_CFG, rd);
        check("global_rw", rd, 8'hfa);
        check("single_rail_on", {7'h00, single_rail}, 8'h01);
        host_write(liu_cfg_pkg::ADDR_GLOBAL_CFG, 8'h00);
        check("single_rail_off", {7'h00, single_rail}, 8'h00);
        $display("test regs done");
    endtask
    task automatic t_pulse();
        host_write(liu_cfg_pkg::ADDR_SEG8_CH0, 8'h25);
        host_write(liu_cfg_pkg::ADDR_GLOBAL_CFG, 8'h10);
        send_word(4'h1, 4'h0, 1'h0, 0, amp);
        check("amp_pos_rise", {1'h0, amp}, 8'h25);
        check("seg_last_reached", {7'h00, seg_last}, 8'h01);
        send_word(4'h0, 4'h1, 1'h0, 0, amp);
        check("amp_neg_rise", {1'h0, amp}, 8'h65);
        host_write(liu_cfg_pkg::ADDR_GLOBAL_CFG, 8'h00);
        send_word(4'h1, 4'h0, 1'h0, 0, amp);
        check("amp_rise_unsampled", {1'h0, amp}, 8'h00);
        send_word(4'h1, 4'h0, 1'h1, 0, amp);
        check("amp_pos_fall", {1'h0, amp}, 8'h25);
        host_write(liu_cfg_pkg::ADDR_GLOBAL_CFG, 8'h80);
        send_word(4'h1, 4'h1, 1'h1, 0, amp);
        check("amp_single_rail_neg", {1'h0, amp}, 8'h25);
        host_write(liu_cfg_pkg::ADDR_GLOBAL_CFG, 8'h00);
        $display("test pulse done");
    endtask
    task automatic t_soft();
        host_write(liu_cfg_pkg::ADDR_SEG8_CH1, 8'h31);
        host_write(liu_cfg_pkg::ADDR_GLOBAL_CFG, 8'h01);
        check("soft_reset_early", {7'h00, internal_reset}, 8'h00);
        for (int i = 0; i < 30 && internal_reset !== 1'h1; i++)
            @(negedge clk);
        check("soft_reset_on", {7'h00, internal_reset}, 8'h01);
        host_read(liu_cfg_pkg::ADDR_SEG8_CH1, rd);
        check("seg8_kept", rd, 8'h31);
        host_read(liu_cfg_pkg::ADDR_GLOBAL_CFG, rd);
        check("global_kept", rd, 8'h01);
        host_write(liu_cfg_pkg::ADDR_GLOBAL_CFG, 8'h00);
        check("soft_reset_off", {7'h00, internal_reset}, 8'h00);
        $display("test soft reset done");
    endtask
    task automatic t_auto();
        receive_signal_loss = 4'h2;
        host_write(liu_cfg_pkg::ADDR_GLOBAL_CFG, 8'h40);
        send_word(4'h0, 4'h0, 1'h0, 1, amp);
        check("auto_ones_on", {7'h00, amp !== 7'h00}, 8'h01);
        host_write(liu_cfg_pkg::ADDR_GLOBAL_CFG, 8'h00);
        send_word(4'h0, 4'h0, 1'h0, 1, amp);
        check("auto_ones_off", {1'h0, amp}, 8'h00);
        receive_signal_loss = 4'h0;
        $display("test auto ones done");
    endtask
    task automatic t_irq();
        channel_irq = 4'h4;
        repeat (8) @(negedge clk);
        check("irq_masked", {7'h00, irq_n}, 8'h01);
        host_write(liu_cfg_pkg::ADDR_GLOBAL_CFG, 8'h02);
        check("irq_enabled", {7'h00, irq_n}, 8'h00);
        channel_irq = 4'h0;
        repeat (8) @(negedge clk);
        check("irq_gone", {7'h00, irq_n}, 8'h01);
        host_write(liu_cfg_pkg::ADDR_GLOBAL_CFG, 8'h00);
        $display("test irq done");
    endtask
    task automatic t_clock();
        int n0;
        n0 = n_retune;
        host_write(liu_cfg_pkg::ADDR_CLK_SELECT, 8'h08);
        check("retune_group", 8'(n_retune - n0), 8'h01);
        host_write(liu_cfg_pkg::ADDR_CLK_SELECT, 8'h09);
        check("retune_other", 8'(n_retune - n0), 8'h01);
        host_write(liu_cfg_pkg::ADDR_CLK_SELECT, 8'h11);
        host_write(liu_cfg_pkg::ADDR_CLK_SELECT, 8'h91);
        check("retune_two_writes", 8'(n_retune - n0), 8'h02);
        check("clock_select", clock_select, 8'h91);
        $display("test clock select done");
    endtask
    task automatic t_rx();
        logic [7:0] cfg[3] = '{8'h00, 8'h20, 8'h08};
        logic [3:0] mid[3] = '{4'h5, 4'ha, 4'ha};
        logic [3:0] fin[3] = '{4'ha, 4'ha, 4'h5};
        run = 1'h1;
        foreach (cfg[i])
        begin
            host_write(liu_cfg_pkg::ADDR_GLOBAL_CFG, cfg[i]);
            rx_bits = 4'h5;
            repeat (3) @(posedge tx_line_clock);
            rx_bits = 4'ha;
            // new bits reach the pins 20 ns on: falling flop takes them first
            #60;
            check("rx_mid", {4'h0, rx_data_out}, {4'h0, mid[i]});
            #30;
            check("rx_end", {4'h0, rx_data_out}, {4'h0, fin[i]});
        end
        run = 1'h0;
        $display("test receive done");
    endtask

    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        #500us;
        n_mismatch++;
        $display("BAD watchdog expected done seen hang");
        stop_test();
    end
    initial
    begin
        {host_cs_n, host_wr_n, host_rd_n} = 3'h7;
        host_addr = 7'h00;
        host_data_in = 8'h00;
        {receive_signal_loss, channel_irq, pos, neg, rx_bits} = '0;
        {send, at_fall} = 2'h0;
        run = 1'h1;
        reset_n = 1'h0;
        repeat (10) @(negedge clk);
        reset_n = 1'h1;
        run = 1'h0;
        t_reset();
        t_regs();
        t_pulse();
        t_soft();
        t_auto();
        t_irq();
        t_clock();
        t_rx();
        stop_test();
    end
endmodule // testbench
